// ===== logic/phy_port_operation_control.sv
// Functional notes
// R01: writing one to bit 15 returns all management registers except sticky ones to defaults, then bit 15 clears itself.
// R02: after a soft reset the manager waits at least 1 us before the next register access.
// R03: loopback at bit 14 runs at the speed and duplex currently held in bits 6, 8 and 13.
// R04: forced speed is {bit 6, bit 13}: 00 10 Mbps, 01 100 Mbps, 10 1000 Mbps, 11 reserved.
// R05: isolate at bit 10 stops driving the mac side outputs and ignores the mac side inputs.
// R06: writing one to bit 9 restarts autonegotiation and the bit then clears itself.
// R07: bit 7 enables the collision test of the port.
// R08: the unidirectional bit is ignored while autonegotiation is on or half duplex is selected.
// R09: with autonegotiation off, full duplex and bit 5 set, transmit proceeds without a valid link.
// R10: with autonegotiation off, full duplex and bit 5 clear, transmit waits for a valid link.
// R11: the unidirectional bit acts only in the 100BASE-FX and 1000BASE-X fiber modes.
// R12: software keeps full duplex while timestamping, link security or legacy-mac eee is active.
// R13: the register is reachable only while page register 31 holds zero.
// R14: software polls until bit 15 reads zero before configuring further.
// R15: autonegotiation enable at bit 12 resets to one and forced settings govern only while it is zero.
// R16: bit 8 one is full duplex, zero half duplex; bit 11 one places the port in power-down.
// R17: bits 4 to 0 read zero and ignore writes; forced speed resets to the 1000 Mbps code.
`timescale 1ns/100ps

module phy_port_operation_control
  import op_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // register access from the serial management engine
  input  wire mgmt_req_s   mgmt_req_i,
  input  wire logic [15:0] page_sel_i,
  output logic      [15:0] mgmt_rdata_o,
  output logic             mgmt_rvalid_o,
  output logic             mgmt_busy_o,
  // media side status
  input  wire media_mode_e media_mode_i,
  input  wire logic        link_ok_i,
  // controls to the port
  output logic             soft_rst_o,
  output logic             an_restart_o,
  output logic             an_en_o,
  output logic [1:0]       speed_o,
  output logic             full_dup_o,
  output logic             loopback_o,
  output logic             power_down_o,
  output logic             coll_test_o,
  output logic             mac_out_en_n_o,
  output logic             mac_in_accept_o,
  output logic             mii_tx_allow_o
);

  // ==========================================================
  // access decode
  function automatic logic hit(input mgmt_req_s req, input logic [15:0] page);
    hit = (req.addr == CTRL_ADDR) && (page == PAGE_MAIN); // R13
  endfunction : hit

  localparam logic [4:0] HOLD_LOAD = 5'(SRST_CYCLES - 1);

  ctrl_s       ctrl_q;
  ctrl_s       ctrl_d;
  ctrl_s       wr_val;
  logic [4:0]  hold_q;
  logic [4:0]  hold_d;
  logic        srst_q;
  logic        srst_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic        busy;
  logic        wr_ok;
  logic        rd_ok;
  logic        uni_active;

  // accesses during the soft reset hold are dropped rather than queued
  assign busy   = ctrl_q.sw_reset;
  assign wr_ok  = mgmt_req_i.wr && hit(mgmt_req_i, page_sel_i) && !busy;
  assign rd_ok  = mgmt_req_i.rd && hit(mgmt_req_i, page_sel_i) && !busy;
  assign wr_val = ctrl_s'(mgmt_req_i.wdata);

  // ==========================================================
  // control register
  always_comb begin
    ctrl_d            = ctrl_q;
    hold_d            = hold_q;
    srst_d            = 1'b0;
    ctrl_d.an_restart = 1'b0; // R06
    if (busy) begin
      if (hold_q == 5'h00) begin
        ctrl_d.sw_reset = 1'b0; // R01
      end else begin
        hold_d = hold_q - 5'h01;
      end
    end else if (wr_ok) begin
      if (wr_val.sw_reset) begin
        ctrl_d          = ctrl_s'(CTRL_RESET); // R01
        ctrl_d.sw_reset = 1'b1;
        hold_d          = HOLD_LOAD;
        srst_d          = 1'b1;
      end else begin
        ctrl_d      = wr_val;
        ctrl_d.rsvd = 5'h00; // R17
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ctrl_q <= ctrl_s'(CTRL_RESET); // R15 R17
      hold_q <= 5'h00;
      srst_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      hold_q <= hold_d;
      srst_q <= srst_d;
    end
  end

  // ==========================================================
  // read path, one cycle after the request
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = rd_ok;
    if (rd_ok) begin
      rdata_d = ctrl_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ==========================================================
  // effects on the port
  // uni only matters for fiber with forced full duplex
  assign uni_active = ctrl_q.uni_en && !ctrl_q.an_en && ctrl_q.full_dup // R08
                    && (media_mode_i == MEDIA_100FX || media_mode_i == MEDIA_1000X); // R11

  assign mgmt_rdata_o    = rdata_q;
  assign mgmt_rvalid_o   = rvalid_q;
  assign mgmt_busy_o     = busy;
  assign soft_rst_o      = srst_q; // R01
  assign an_restart_o    = ctrl_q.an_restart; // R06
  assign an_en_o         = ctrl_q.an_en; // R15
  assign speed_o         = {ctrl_q.speed_msb, ctrl_q.speed_lsb}; // R04 R03
  assign full_dup_o      = ctrl_q.full_dup; // R16
  assign loopback_o      = ctrl_q.loopback; // R03
  assign power_down_o    = ctrl_q.power_down; // R16
  assign coll_test_o     = ctrl_q.coll_test; // R07
  assign mac_out_en_n_o  = ctrl_q.isolate; // R05
  assign mac_in_accept_o = !ctrl_q.isolate; // R05
  assign mii_tx_allow_o  = link_ok_i || uni_active; // R09 R10

  // ==========================================================
  // checks
  srst_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R01
    wr_ok && wr_val.sw_reset |=> ##(SRST_CYCLES - 1) ctrl_q.sw_reset ##1 !ctrl_q.sw_reset)
    else $error("soft reset bit did not self clear after the hold");

  srst_defaults_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R01
    wr_ok && wr_val.sw_reset |=> soft_rst_o && an_en_o && speed_o == SPEED_1000
      && !loopback_o && !full_dup_o && !power_down_o)
    else $error("soft reset did not restore defaults");

  srst_holdoff_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R02
    mgmt_req_i.wr && busy && !(hold_q == 5'h00) |=> $stable(ctrl_q.loopback)
      && $stable(ctrl_q.an_en))
    else $error("write accepted during soft reset hold");

  restart_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R06
    wr_ok && !wr_val.sw_reset && wr_val.an_restart |=> an_restart_o ##1 !an_restart_o)
    else $error("restart negotiation not a one cycle pulse");

  speed_map_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R04
    wr_ok && !wr_val.sw_reset |=> speed_o == {$past(mgmt_req_i.wdata[SPEED_MSB_BIT]),
      $past(mgmt_req_i.wdata[SPEED_LSB_BIT])} && coll_test_o == $past(wr_val.coll_test))
    else $error("forced speed or collision test field mismapped");

  isolate_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R05
    wr_ok && !wr_val.sw_reset |=> mac_out_en_n_o == $past(wr_val.isolate)
      && mac_in_accept_o == !$past(wr_val.isolate))
    else $error("isolate did not gate the mac side");

  uni_ignored_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R08
    (an_en_o || !full_dup_o || media_mode_i == MEDIA_COPPER) |-> mii_tx_allow_o == link_ok_i)
    else $error("unidirectional bit acted when it must be ignored");

  uni_fiber_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R09
    !an_en_o && full_dup_o && ctrl_q.uni_en && media_mode_i == MEDIA_1000X |-> mii_tx_allow_o)
    else $error("unidirectional transmit blocked without link");

  rsvd_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R17
    mgmt_rvalid_o |-> mgmt_rdata_o[4:0] == 5'h00)
    else $error("reserved bits read nonzero");

  page_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R13
    mgmt_req_i.wr && page_sel_i != PAGE_MAIN && !busy |=> $stable(ctrl_q) || an_restart_o == 1'b0
      && $stable(speed_o) && $stable(loopback_o))
    else $error("write taken with page register nonzero");

  uni_link_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R10
    !an_en_o && full_dup_o && !ctrl_q.uni_en |-> mii_tx_allow_o == link_ok_i)
    else $error("transmit allowed without link while unidirectional is clear");

  loop_speed_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R03
    wr_ok && !wr_val.sw_reset && wr_val.loopback |=> loopback_o
      && speed_o == {$past(wr_val.speed_msb), $past(wr_val.speed_lsb)}
      && full_dup_o == $past(wr_val.full_dup))
    else $error("loopback not at the selected speed and duplex");

  dup_power_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // R16
    wr_ok && !wr_val.sw_reset |=> full_dup_o == $past(wr_val.full_dup)
      && power_down_o == $past(wr_val.power_down) && an_en_o == $past(wr_val.an_en))
    else $error("duplex, power-down or negotiation enable mismapped");

endmodule : phy_port_operation_control

// ===== logic/op_ctrl_pkg.sv
package op_ctrl_pkg;

  // ==========================================================
  // register map
  localparam logic [4:0]  CTRL_ADDR      = 5'h00;
  localparam logic [15:0] PAGE_MAIN      = 16'h0000;

  // ==========================================================
  // field positions
  localparam int          SW_RESET_BIT   = 15;
  localparam int          LOOPBACK_BIT   = 14;
  localparam int          SPEED_LSB_BIT  = 13;
  localparam int          AN_EN_BIT      = 12;
  localparam int          PWR_DOWN_BIT   = 11;
  localparam int          ISOLATE_BIT    = 10;
  localparam int          AN_RESTART_BIT = 9;
  localparam int          FULL_DUP_BIT   = 8;
  localparam int          COLL_TEST_BIT  = 7;
  localparam int          SPEED_MSB_BIT  = 6;
  localparam int          UNI_EN_BIT     = 5;

  // ==========================================================
  // reset value: autonegotiation on, forced speed code 10
  localparam logic [15:0] CTRL_RESET     = 16'h1040;

  // ==========================================================
  // speed codes, upper bit first
  localparam logic [1:0]  SPEED_10       = 2'h0;
  localparam logic [1:0]  SPEED_100      = 2'h1;
  localparam logic [1:0]  SPEED_1000     = 2'h2;

  // ==========================================================
  // timing
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          SRST_HOLD_NS   = 1000;
  localparam int          SRST_CYCLES    = (SRST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MEDIA_COPPER,
    MEDIA_100FX,
    MEDIA_1000X,
    MEDIA_OTHER
  } media_mode_e;

  typedef struct packed {
    logic       sw_reset;
    logic       loopback;
    logic       speed_lsb;
    logic       an_en;
    logic       power_down;
    logic       isolate;
    logic       an_restart;
    logic       full_dup;
    logic       coll_test;
    logic       speed_msb;
    logic       uni_en;
    logic [4:0] rsvd;
  } ctrl_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mgmt_req_s;

endpackage : op_ctrl_pkg

// ===== dv/mgmt_ctrl_model.sv
`timescale 1ns/100ps
// ====================
// station management controller model
module mgmt_ctrl_model
  import op_ctrl_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output mgmt_req_s        req_o,
  output logic      [15:0] page_o
);
  initial begin
    req_o  = '0;
    page_o = PAGE_MAIN;
  end
  task automatic set_page(input logic [15:0] p);
    @(posedge sys_clk_i);
    #1;
    page_o = p;
  endtask : set_page
  // one-cycle strobe; released lines show inverted values, not stale ones
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
                      output logic v, output logic [15:0] q);
    @(posedge sys_clk_i);
    #1;
    req_o = {w, !w, a, d};
    @(posedge sys_clk_i);
    #1;
    v     = rvalid_i;
    q     = rdata_i;
    req_o = {2'b00, ~a, ~d};
  endtask : xfer
  // hold off after soft reset, then poll, at most 8 reads, until bit 15 clears
  task automatic poll(output logic [15:0] q);
    logic v;
    repeat (SRST_CYCLES) @(posedge sys_clk_i);
    for (int k = 0; k < 8; k++) begin
      xfer(1'b0, CTRL_ADDR, 16'h0000, v, q);
      if (v === 1'b1 && q[SW_RESET_BIT] === 1'b0) break;
    end
  endtask : poll
endmodule : mgmt_ctrl_model

// ===== dv/phy_port_operation_control_tb.sv
`timescale 1ns/100ps
// ====================
// testbench
module phy_port_operation_control_tb
  import op_ctrl_pkg::*;
;
  logic        sys_clk, rstn, link, v, rvalid, busy, srst, anr, an_en;
  logic        fdup, lb, pd, ct, moen_n, min_acc, tx_allow;
  logic [1:0]  spd;
  logic [15:0] page, rdata, q, d;
  logic [31:0] seed;
  mgmt_req_s   req;
  media_mode_e media;
  int          error_cnt, n_tests;

  mgmt_ctrl_model mgmt (.sys_clk_i(sys_clk), .rdata_i(rdata), .rvalid_i(rvalid),
                        .req_o(req), .page_o(page));
  phy_port_operation_control DUT (
    .sys_clk_i(sys_clk), .rstn_i(rstn), .mgmt_req_i(req), .page_sel_i(page),
    .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid), .mgmt_busy_o(busy),
    .media_mode_i(media), .link_ok_i(link), .soft_rst_o(srst), .an_restart_o(anr),
    .an_en_o(an_en), .speed_o(spd), .full_dup_o(fdup), .loopback_o(lb),
    .power_down_o(pd), .coll_test_o(ct), .mac_out_en_n_o(moen_n),
    .mac_in_accept_o(min_acc), .mii_tx_allow_o(tx_allow));

  // ====================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic exp_tx(logic [15:0] c, media_mode_e md, logic l);
    return l | (c[UNI_EN_BIT] & !c[AN_EN_BIT] & c[FULL_DUP_BIT]
                & (md == MEDIA_100FX || md == MEDIA_1000X));
  endfunction : exp_tx
  // self-clearing and reserved bits read back as zero
  function automatic logic [15:0] exp_rd(logic [15:0] c);
    logic [15:0] r;
    r                 = c;
    r[SW_RESET_BIT]   = 1'b0;
    r[AN_RESTART_BIT] = 1'b0;
    r[4:0]            = 5'h00;
    return r;
  endfunction : exp_rd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // ====================
  // clock, watchdog, sequence
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #1000000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    seed = 32'h42db;
    error_cnt = 0;
    n_tests = 0;
    rstn = 1'b0;
    link = 1'b0;
    media = MEDIA_COPPER;
    repeat (8) @(posedge sys_clk);
    #1 rstn = 1'b1;
    mgmt.xfer(1'b0, CTRL_ADDR, 16'h0000, v, q);
    chk(q, CTRL_RESET, "reset value");
    chk(spd, SPEED_1000, "reset speed");
    for (int i = 0; i < 40; i++) begin
      // no timestamping or link security here, so half duplex may be drawn
      d = 16'(xs());
      if (i == 0) d = 16'h7fff;
      if (i == 1) d = 16'h0120;
      d[15] = 1'b0;
      mgmt.xfer(1'b1, CTRL_ADDR, d, v, q);
      chk(anr, d[9], "restart pulse");
      chk(spd, {d[6], d[13]}, "speed");
      chk(lb, d[14], "loopback");
      chk({pd, fdup}, {d[11], d[8]}, "power duplex");
      chk(ct, d[7], "collision test");
      chk({moen_n, min_acc}, {d[10], !d[10]}, "isolate");
      chk(an_en, d[12], "autoneg enable");
      for (int j = 0; j < 8; j++) begin
        @(posedge sys_clk);
        #1;
        media = media_mode_e'(j[1:0]);
        link = j[2];
        @(negedge sys_clk);
        chk(tx_allow, exp_tx(d, media, link), "tx allow");
      end
      mgmt.xfer(1'b0, CTRL_ADDR, 16'h0000, v, q);
      chk(q, exp_rd(d), "readback");
    end
    mgmt.set_page(16'h0001);
    mgmt.xfer(1'b1, CTRL_ADDR, 16'h0000, v, q);
    mgmt.xfer(1'b0, CTRL_ADDR, 16'h0000, v, q);
    chk(v, 1'b0, "read off page");
    mgmt.set_page(PAGE_MAIN);
    mgmt.xfer(1'b1, 5'h01, 16'h0000, v, q);
    mgmt.xfer(1'b0, CTRL_ADDR, 16'h0000, v, q);
    chk(q, exp_rd(d), "refused write");
    mgmt.xfer(1'b1, CTRL_ADDR, 16'hffff, v, q);
    chk({srst, busy}, 2'b11, "soft reset start");
    // the device drops accesses inside the hold, so neither of these may land
    mgmt.xfer(1'b1, CTRL_ADDR, 16'h4000, v, q);
    mgmt.xfer(1'b0, CTRL_ADDR, 16'h0000, v, q);
    chk({v, srst}, 2'b00, "held off");
    mgmt.poll(q);
    chk(q, CTRL_RESET, "defaults after soft reset");
    give_verdict();
  end
endmodule : phy_port_operation_control_tb
